// *** smon_pkg.sv ***
// package for the supply monitor status block: offsets, fields, reset values
package smon_pkg;
	// register word addresses
	localparam logic [7:0] SMON_ADDR_IRQ_MASK = 8'h0E;
	localparam logic [7:0] SMON_ADDR_IRQ_STATUS = 8'h0F;
	localparam logic [7:0] SMON_ADDR_VREG = 8'h10;
	localparam logic [7:0] SMON_ADDR_MONCFG = 8'h11;
	// field positions
	localparam int SMON_VREG_DEXT_BIT = 7;
	localparam int SMON_VREG_DOK_BIT = 6;
	localparam int SMON_MON_OK_BIT = 5;
	localparam int SMON_MON_HR_BIT = 4;
	localparam int SMON_IRQ_LOW_BIT = 7;
	// reset values
	localparam logic [3:0] SMON_VTH_RESET = 4'h2;
	localparam logic SMON_HR_RESET = 1'b0;
	localparam logic SMON_DEXT_RESET = 1'b0;
	localparam logic [7:0] SMON_MASK_RESET = 8'h00;
	// threshold tables in millivolts
	localparam int SMON_HI_BASE_MV = 2550;
	localparam int SMON_HI_STEP_MV = 75;
	localparam int SMON_LO_BASE_MV = 1700;
	localparam int SMON_LO_STEP_MV = 50;
	// transceiver states in which the monitor sleeps
	localparam logic [4:0] SMON_STATE_P_ON = 5'h00;
	localparam logic [4:0] SMON_STATE_SLEEP = 5'h0F;
	// monitor configuration carried between modules
	typedef struct packed {
		logic rangeHigh;
		logic [3:0] thresholdCode;
	} smon_cfg_t;
endpackage

// *** smon_sync.sv ***
// two flop synchroniser for an asynchronous level
`timescale 1ns/100ps
module smon_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstB,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic stage1_q;
	logic stage1_d;
	logic stage2_d;

	// next values: first stage feeds only the second
	always_comb begin
		stage1_d = din;
		stage2_d = stage1_q;
	end

	// register both stages
	always_ff @(posedge clk or negedge rstB) begin
		if (!rstB) begin
			stage1_q <= RESET_VAL;
			dout <= RESET_VAL;
		end else begin
			stage1_q <= stage1_d;
			dout <= stage2_d;
		end
	end
endmodule

// *** smon_top.sv ***
// supply monitor and digital regulator status with register port
// Functional notes
// - Bit 6 of the regulator register reports the digital supply settled, forced 1 when external.
// - The settled flag reads 0 after reset or while unstable, 1 once settled or while external is selected.
// - Bit 5 of the monitor register shows the supply above threshold, 0 below, reset 0.
// - The monitor is idle in the power-on and sleep states, with no compare and no event.
// - The low-supply event is raised only on a 1 to 0 change of the status.
// - No event at power up below threshold, nor when a new threshold stays above supply.
// - The event is flagged in the shared status at 0x0F with an enable bit in the mask at 0x0E.
// - Bit 4 picks the threshold range, 0 low after reset, 1 high.
// - Bits 3 to 0 pick the threshold; high range 2.550 V plus 0.075 V a step to 3.675 V.
// - Low range is 1.7 V plus 0.05 V a step to 2.45 V; the whole span is 1.7 V to 3.675 V.
// - The external regulator select at 1 disables the internal digital regulator.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module smon_top (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	// transceiver state from the state machine
	input wire logic [4:0] trxState,
	// analog comparator and regulator inputs, asynchronous
	input wire logic supplyAboveRaw,
	input wire logic regulatorStableRaw,
	// analog control outputs
	output smon_pkg::smon_cfg_t monitorCfg,
	output logic monitorEnable,
	output logic internalRegulatorOn,
	// low supply event flag, registered
	output logic lowSupplyPending
);
	logic rstSync1_q;
	logic rstSyncB_q;
	logic compSync;
	logic regOkSync;
	logic monActive;
	logic [3:0] vthCode_q;
	logic [3:0] vthCode_d;
	logic rangeHigh_q;
	logic rangeHigh_d;
	logic dvregExt_q;
	logic dvregExt_d;
	logic [7:0] irqMask_q;
	logic [7:0] irqMask_d;
	logic aboveStat_q;
	logic aboveStat_d;
	logic dvddOk_q;
	logic dvddOk_d;
	logic lowFlag_q;
	logic lowFlag_d;
	logic monEn_q;
	logic monEn_d;
	logic [7:0] rdData_d;
	logic fallEdge;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstSync1_q <= 1'b0;
			rstSyncB_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSyncB_q <= rstSync1_q;
		end
	end

	// comparator and regulator levels into the core domain
	smon_sync #(.RESET_VAL(1'b0)) u_compSync (
		.clk(core_clk),
		.rstB(rstSyncB_q),
		.din(supplyAboveRaw),
		.dout(compSync)
	);
	smon_sync #(.RESET_VAL(1'b0)) u_regSync (
		.clk(core_clk),
		.rstB(rstSyncB_q),
		.din(regulatorStableRaw),
		.dout(regOkSync)
	);

	// monitor idle in power-on and sleep
	assign monActive = (trxState != smon_pkg::SMON_STATE_P_ON) &&
		(trxState != smon_pkg::SMON_STATE_SLEEP);

	// status update: hold last value while idle, fall detect from settled status
	always_comb begin
		aboveStat_d = aboveStat_q;
		if (monActive) begin
			aboveStat_d = compSync;
		end
	end
	assign fallEdge = monActive && aboveStat_q && !compSync;

	// configuration and mask writes
	always_comb begin
		vthCode_d = vthCode_q;
		rangeHigh_d = rangeHigh_q;
		dvregExt_d = dvregExt_q;
		irqMask_d = irqMask_q;
		if (regWrEn) begin
			unique case (regAddr)
				smon_pkg::SMON_ADDR_MONCFG: begin
					// reserved bits and status bit ignore writes
					vthCode_d = regWrData[3:0];
					rangeHigh_d = regWrData[smon_pkg::SMON_MON_HR_BIT];
				end
				smon_pkg::SMON_ADDR_VREG: begin
					dvregExt_d = regWrData[smon_pkg::SMON_VREG_DEXT_BIT];
				end
				smon_pkg::SMON_ADDR_IRQ_MASK: begin
					irqMask_d = regWrData;
				end
				default: begin
				end
			endcase
		end
	end

	// settled flag: forced high when external regulator selected
	always_comb begin
		dvddOk_d = dvregExt_q ? 1'b1 : regOkSync;
	end

	// event flag: set when enabled edge, cleared by status read, set wins
	always_comb begin
		lowFlag_d = lowFlag_q;
		if (regRdEn && (regAddr == smon_pkg::SMON_ADDR_IRQ_STATUS)) begin
			lowFlag_d = 1'b0;
		end
		if (fallEdge && irqMask_q[smon_pkg::SMON_IRQ_LOW_BIT]) begin
			lowFlag_d = 1'b1;
		end
	end

	// read mux, unmapped reads return zero
	always_comb begin
		rdData_d = 8'h00;
		if (regRdEn) begin
			unique case (regAddr)
				smon_pkg::SMON_ADDR_MONCFG: begin
					rdData_d[3:0] = vthCode_q;
					rdData_d[smon_pkg::SMON_MON_HR_BIT] = rangeHigh_q;
					rdData_d[smon_pkg::SMON_MON_OK_BIT] = aboveStat_q;
				end
				smon_pkg::SMON_ADDR_VREG: begin
					rdData_d[smon_pkg::SMON_VREG_DEXT_BIT] = dvregExt_q;
					// forced high at once, so a read right after selecting external sees 1
					rdData_d[smon_pkg::SMON_VREG_DOK_BIT] = dvregExt_q | dvddOk_q;
				end
				smon_pkg::SMON_ADDR_IRQ_MASK: begin
					rdData_d = irqMask_q;
				end
				smon_pkg::SMON_ADDR_IRQ_STATUS: begin
					rdData_d[smon_pkg::SMON_IRQ_LOW_BIT] = lowFlag_q;
				end
				default: begin
				end
			endcase
		end
	end

	// enable of the analog comparator
	always_comb begin
		monEn_d = monActive;
	end

	// register all state
	always_ff @(posedge core_clk or negedge rstSyncB_q) begin
		if (!rstSyncB_q) begin
			vthCode_q <= smon_pkg::SMON_VTH_RESET;
			rangeHigh_q <= smon_pkg::SMON_HR_RESET;
			dvregExt_q <= smon_pkg::SMON_DEXT_RESET;
			irqMask_q <= smon_pkg::SMON_MASK_RESET;
			aboveStat_q <= 1'b0;
			dvddOk_q <= 1'b0;
			lowFlag_q <= 1'b0;
			monEn_q <= 1'b0;
			regRdData <= 8'h00;
		end else begin
			vthCode_q <= vthCode_d;
			rangeHigh_q <= rangeHigh_d;
			dvregExt_q <= dvregExt_d;
			irqMask_q <= irqMask_d;
			aboveStat_q <= aboveStat_d;
			dvddOk_q <= dvddOk_d;
			lowFlag_q <= lowFlag_d;
			monEn_q <= monEn_d;
			regRdData <= rdData_d;
		end
	end

	// outputs straight from flops
	assign monitorCfg.rangeHigh = rangeHigh_q;
	assign monitorCfg.thresholdCode = vthCode_q;
	assign monitorEnable = monEn_q;
	assign internalRegulatorOn = !dvregExt_q;
	assign lowSupplyPending = lowFlag_q;
endmodule

// *** smon_top_assertions.sv ***
// port checker for the supply monitor status block
`timescale 1ns/100ps
module smon_top_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regRdData,
	// monitor side
	input wire logic [4:0] trxState,
	input wire logic supplyAboveRaw,
	input wire logic regulatorStableRaw,
	input wire smon_pkg::smon_cfg_t monitorCfg,
	input wire logic monitorEnable,
	input wire logic internalRegulatorOn,
	input wire logic lowSupplyPending
);
	// all checks share the core clock and reset
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	a_rd_zero: assert property ($past(!regRdEn || regAddr < 8'h0E || regAddr > 8'h11)
		|-> regRdData == 8'h00) else $error("read data not zero");
	a_ext_settled: assert property ($past(regRdEn && regAddr == 8'h10 && !internalRegulatorOn)
		|-> regRdData[6]) else $error("settled not forced");
	a_rsvd_zero: assert property ($past(regRdEn && regAddr == 8'h11)
		|-> regRdData[7:6] == 2'h0) else $error("reserved bits set");
	a_cfg_read: assert property ($past(regRdEn && regAddr == 8'h11)
		|-> regRdData[4:0] == monitorCfg) else $error("config readback wrong");
	a_cfg_write: assert property (regWrEn && regAddr == 8'h11
		|=> monitorCfg == $past(regWrData[4:0])) else $error("config write lost");
	a_reg_off: assert property (regWrEn && regAddr == 8'h10
		|=> internalRegulatorOn == !$past(regWrData[7])) else $error("regulator on wrong");
	a_idle_off: assert property ($past(trxState == 5'h00 || trxState == 5'h0F)
		|-> !monitorEnable) else $error("monitor active when idle");
	a_event_fall: assert property ($rose(lowSupplyPending) && $past(monitorEnable)
		|-> !$past(supplyAboveRaw, 3) && $past(supplyAboveRaw, 4))
		else $error("event without falling supply");
	a_event_read: assert property ($past(regRdEn && regAddr == 8'h0F && lowSupplyPending)
		|-> regRdData[7]) else $error("event not reported");
endmodule
bind smon_top smon_top_assertions smon_top_assertions_i (.core_clk, .rst_b, .regAddr,
	.regWrData, .regWrEn, .regRdEn, .regRdData, .trxState, .supplyAboveRaw,
	.regulatorStableRaw, .monitorCfg, .monitorEnable, .internalRegulatorOn, .lowSupplyPending);

// *** smon_top_tb.sv ***
// self-checking bench for the supply monitor status block
`timescale 1ns/100ps
module smon_top_tb;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [4:0] trxState = 5'h00;
	logic supplyAboveRaw = 1'b0;
	logic regulatorStableRaw = 1'b0;
	logic [7:0] regRdData;
	smon_pkg::smon_cfg_t monitorCfg;
	logic monitorEnable, internalRegulatorOn, lowSupplyPending;
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 87952;
	logic [7:0] d;
	logic [7:0] q;
	// free running 100 MHz clock
	always #5 core_clk = ~core_clk;
	smon_top smon_top_i (.core_clk, .rst_b, .regAddr, .regWrData, .regWrEn, .regRdEn,
		.regRdData, .trxState, .supplyAboveRaw, .regulatorStableRaw, .monitorCfg,
		.monitorEnable, .internalRegulatorOn, .lowSupplyPending);
	// compare one byte result
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// one cycle register write
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask
	// one cycle read, data taken in the following cycle
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1 q = regRdData;
		chk(q, exp);
	endtask
	// comparator level held long enough to cross the synchroniser
	task automatic supply(input logic v);
		supplyAboveRaw <= v;
		waitc(6);
	endtask
	task automatic complete_run;
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		waitc(3);
		rst_b <= 1'b1;
		waitc(3);
		rdchk(8'h11, 8'h02);
		rdchk(8'h10, 8'h00);
		rdchk(8'h0E, 8'h00);
		rdchk(8'h20, 8'h00);
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 8'hFF : 8'($random(seed));
			wr(8'h11, d);
			#1 chk({3'h0, monitorCfg}, {3'h0, d[4:0]});
			rdchk(8'h11, {3'h0, d[4:0]});
		end
		regulatorStableRaw <= 1'b1;
		waitc(4);
		rdchk(8'h10, 8'h40);
		wr(8'h10, 8'h80);
		regulatorStableRaw <= 1'b0;
		waitc(4);
		chk({7'h0, internalRegulatorOn}, 8'h00);
		rdchk(8'h10, 8'hC0);
		wr(8'h10, 8'h00);
		waitc(4);
		rdchk(8'h10, 8'h00);
		wr(8'h0E, 8'h80);
		supply(1'b1);
		supply(1'b0);
		rdchk(8'h0F, 8'h00);
		trxState <= 5'h08;
		supply(1'b0);
		chk({7'h0, monitorEnable}, 8'h01);
		rdchk(8'h0F, 8'h00);
		supply(1'b1);
		rdchk(8'h11, {3'h1, d[4:0]});
		supply(1'b0);
		chk({7'h0, lowSupplyPending}, 8'h01);
		rdchk(8'h0F, 8'h80);
		rdchk(8'h0F, 8'h00);
		wr(8'h0E, 8'h00);
		supply(1'b1);
		supply(1'b0);
		rdchk(8'h0F, 8'h00);
		trxState <= 5'h0F;
		waitc(2);
		chk({7'h0, monitorEnable}, 8'h00);
		complete_run();
	end
endmodule
